// >>> hdl/htm_cmp.sv
// Threshold comparator with hysteresis and activation mode decode
module htm_cmp (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   htm_cmp_if.cmp cmp
);
   logic cond_r;
   logic exceed;
   logic [1:0] code_a;
   logic [1:0] code_b;
   logic [15:0] lo_lim;
   logic [16:0] hi_lim;

   // Exceed type, action at threshold, action at hysteresis edge
   always_comb begin
      case (cmp.mode)
         4'h0: {exceed, code_a, code_b} = 5'h14;
         4'h1: {exceed, code_a, code_b} = 5'h11;
         4'h2: {exceed, code_a, code_b} = 5'h04;
         4'h3: {exceed, code_a, code_b} = 5'h01;
         4'h4: {exceed, code_a, code_b} = 5'h16;
         4'h5: {exceed, code_a, code_b} = 5'h12;
         4'h6: {exceed, code_a, code_b} = 5'h06;
         4'h7: {exceed, code_a, code_b} = 5'h02;
         4'h8: {exceed, code_a, code_b} = 5'h18;
         4'h9: {exceed, code_a, code_b} = 5'h19;
         4'hA: {exceed, code_a, code_b} = 5'h08;
         4'hB: {exceed, code_a, code_b} = 5'h09;
         default: {exceed, code_a, code_b} = 5'h14;
      endcase
      // Clamp so a large band never wraps below zero
      lo_lim = (cmp.thr > cmp.hyst) ? 16'(cmp.thr - cmp.hyst) : 16'h0000;
      hi_lim = {1'b0, cmp.thr} + {1'b0, cmp.hyst};
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         cond_r <= 1'b0;
      end else if (exceed) begin
         if (cmp.meas > cmp.thr) begin
            cond_r <= 1'b1;
         end else if (cmp.meas < lo_lim) begin
            cond_r <= 1'b0;
         end
      end else begin
         if (cmp.meas < cmp.thr) begin
            cond_r <= 1'b1;
         end else if ({1'b0, cmp.meas} > hi_lim) begin
            cond_r <= 1'b0;
         end
      end
   end

   assign cmp.cond = cond_r;
   assign cmp.act = cond_r ? htm_pkg::htm_act_t'(code_a)
                           : htm_pkg::htm_act_t'(code_b);
endmodule

// >>> hdl/htm_cmp_if.sv
// Carrier between monitor core and threshold comparator
interface htm_cmp_if;
   logic [15:0] meas;
   logic [15:0] thr;
   logic [15:0] hyst;
   logic [3:0] mode;
   logic cond;
   htm_pkg::htm_act_t act;
   modport ctl (output meas, thr, hyst, mode, input cond, act);
   modport cmp (input meas, thr, hyst, mode, output cond, act);
endinterface

// >>> hdl/htm_monitor.sv
// Absolute-humidity limit monitor with delays and telegram scheduling
//
// Overview of operation
// - on-change off means no change telegram
// - cyclic setting one or more sends periodically
// - on-change on sends every toggle
// - both off means never transmitted
// - cyclic period is setting times ten seconds
// - cyclic setting zero disables periodic sends
// - threshold chosen from eleven fixed levels
// - hysteresis none, 2, 3, 5, 7, 10
// - exceed modes act above, release below band
// - undershoot modes act below, release above band
// - twelve modes with on, off, silent edges
// - silent condition also suppresses cyclic sends
// - threshold source config, 16-bit, 8-bit, teaching
// - teach command latches present measurement
// - reload drops external thresholds until new arrives
// - switch-on delay; cyclic keeps reporting zero
// - switch-off delay; cyclic keeps reporting one
// - limit output is a one-bit object
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`include "htm_params.svh"

module htm_monitor #(
   parameter int CYCLES_PER_SEC = `HTM_SEC_NS / `HTM_CLK_NS,
   parameter logic [15:0] PCT_STEP = `HTM_PCT_STEP
) (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_limit,
   output logic o_tx_strobe,
   output logic o_tx_value
);
   localparam int PW = $clog2(CYCLES_PER_SEC + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_SEC - 1);

   logic [15:0] cfg_level_r;
   logic [15:0] cfg_send_r;
   logic [15:0] cfg_delay_r;
   logic [15:0] meas_r;
   logic [15:0] ext16_r;
   logic [7:0] ext8_r;
   logic [15:0] teach_r;
   logic ext_valid_r;
   logic wait_r;
   logic [31:0] rdata_r;
   logic [31:0] rd_nxt;
   logic req_go;
   logic wr_go;
   logic [PW-1:0] pre_r;
   logic tick;
   logic [10:0] cyc_cnt_r;
   logic [10:0] cyc_cnt_inc;
   logic [10:0] cyc_period;
   logic cyc_fire;
   htm_pkg::htm_state_t state_r;
   logic [11:0] dly_cnt_r;
   logic [11:0] dly_cnt_inc;
   logic [PW-1:0] dly_pre_r;
   logic dly_tick;
   logic [11:0] dly_on;
   logic [11:0] dly_off;
   logic limit_r;
   logic tx_strobe_r;
   logic tx_value_r;
   logic [15:0] thr_cfg;
   logic [15:0] hyst_cfg;
   logic [15:0] thr_act;
   logic [15:0] pct_thr;
   logic silent;
   logic desired;
   logic apply;
   logic chg_send;
   htm_pkg::htm_src_t src;

   htm_cmp_if cif ();

   htm_cmp u_cmp (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .cmp (cif.cmp)
   );

   function automatic logic [15:0] wm16(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
      logic [15:0] res;
      res = old;
      if (be[0]) begin
         res[7:0] = wd[7:0];
      end
      if (be[1]) begin
         res[15:8] = wd[15:8];
      end
      return res;
   endfunction

   function automatic logic [11:0] dly_sec(input logic [3:0] idx);
      case (idx)
         4'h1: dly_sec = `HTM_DLY_1S;
         4'h2: dly_sec = `HTM_DLY_3S;
         4'h3: dly_sec = `HTM_DLY_5S;
         4'h4: dly_sec = `HTM_DLY_10S;
         4'h5: dly_sec = `HTM_DLY_15S;
         4'h6: dly_sec = `HTM_DLY_30S;
         4'h7: dly_sec = `HTM_DLY_1M;
         4'h8: dly_sec = `HTM_DLY_3M;
         4'h9: dly_sec = `HTM_DLY_5M;
         4'hA: dly_sec = `HTM_DLY_10M;
         4'hB: dly_sec = `HTM_DLY_15M;
         4'hC: dly_sec = `HTM_DLY_30M;
         4'hD: dly_sec = `HTM_DLY_60M;
         default: dly_sec = `HTM_DLY_0;
      endcase
   endfunction

   // One wait state: answer in the cycle after the request is seen
   assign req_go = (i_avs_read | i_avs_write) & wait_r;
   assign wr_go = i_avs_write & ~wait_r;

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= ~req_go;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         rdata_r <= 32'h00000000;
      end else if (req_go && i_avs_read) begin
         rdata_r <= rd_nxt;
      end
   end

   always_comb begin
      case (i_avs_address)
         `HTM_ADDR_LEVEL: rd_nxt = {16'h0000, cfg_level_r};
         `HTM_ADDR_SEND: rd_nxt = {16'h0000, cfg_send_r};
         `HTM_ADDR_DELAY: rd_nxt = {16'h0000, cfg_delay_r};
         `HTM_ADDR_MEAS: rd_nxt = {16'h0000, meas_r};
         `HTM_ADDR_EXT16: rd_nxt = {16'h0000, ext16_r};
         `HTM_ADDR_EXT8: rd_nxt = {24'h000000, ext8_r};
         `HTM_ADDR_TEACH: rd_nxt = {16'h0000, teach_r};
         `HTM_ADDR_STATUS: rd_nxt = {thr_act, 10'h000, state_r,
                                     ext_valid_r, cif.cond, limit_r};
         default: rd_nxt = 32'h00000000;
      endcase
   end

   // Configuration and measurement registers
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         cfg_level_r <= `HTM_RST_LEVEL;
         cfg_send_r <= `HTM_RST_SEND;
         cfg_delay_r <= `HTM_RST_DELAY;
         meas_r <= 16'h0000;
      end else if (wr_go) begin
         case (i_avs_address)
            `HTM_ADDR_LEVEL: cfg_level_r <= wm16(cfg_level_r,
               i_avs_writedata, i_avs_byteenable) & `HTM_MASK_LEVEL;
            `HTM_ADDR_SEND: cfg_send_r <= wm16(cfg_send_r,
               i_avs_writedata, i_avs_byteenable) & `HTM_MASK_SEND;
            `HTM_ADDR_DELAY: cfg_delay_r <= wm16(cfg_delay_r,
               i_avs_writedata, i_avs_byteenable) & `HTM_MASK_DELAY;
            `HTM_ADDR_MEAS: meas_r <= wm16(meas_r,
               i_avs_writedata, i_avs_byteenable);
            default: meas_r <= meas_r;
         endcase
      end
   end

   assign src = htm_pkg::htm_src_t'(
      cfg_level_r[`HTM_SRC_MSB:`HTM_SRC_LSB]);

   // value stored from its own object
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         ext16_r <= 16'h0000;
         ext8_r <= 8'h00;
      end else if (wr_go) begin
         if (i_avs_address == `HTM_ADDR_EXT16) begin
            ext16_r <= wm16(ext16_r, i_avs_writedata, i_avs_byteenable);
         end
         if (i_avs_address == `HTM_ADDR_EXT8 && i_avs_byteenable[0]) begin
            ext8_r <= i_avs_writedata[7:0];
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         teach_r <= 16'h0000;
      end else if (wr_go && i_avs_address == `HTM_ADDR_TEACH &&
                   i_avs_writedata[`HTM_TEACH_BIT] &&
                   src == htm_pkg::HTM_SRC_TEACH) begin
         teach_r <= meas_r;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         ext_valid_r <= 1'b0;
      end else if (wr_go) begin
         if (i_avs_address == `HTM_ADDR_RELOAD) begin
            ext_valid_r <= 1'b0;
         end else if ((i_avs_address == `HTM_ADDR_EXT16 &&
                       src == htm_pkg::HTM_SRC_EXT16) ||
                      (i_avs_address == `HTM_ADDR_EXT8 &&
                       src == htm_pkg::HTM_SRC_EXT8) ||
                      (i_avs_address == `HTM_ADDR_TEACH &&
                       i_avs_writedata[`HTM_TEACH_BIT] &&
                       src == htm_pkg::HTM_SRC_TEACH)) begin
            ext_valid_r <= 1'b1;
         end
      end
   end

   always_comb begin
      case (cfg_level_r[`HTM_THR_MSB:`HTM_THR_LSB])
         4'h1: thr_cfg = `HTM_THR_15;
         4'h2: thr_cfg = `HTM_THR_20;
         4'h3: thr_cfg = `HTM_THR_25;
         4'h4: thr_cfg = `HTM_THR_30;
         4'h5: thr_cfg = `HTM_THR_35;
         4'h6: thr_cfg = `HTM_THR_40;
         4'h7: thr_cfg = `HTM_THR_50;
         4'h8: thr_cfg = `HTM_THR_60;
         4'h9: thr_cfg = `HTM_THR_70;
         4'hA: thr_cfg = `HTM_THR_80;
         default: thr_cfg = `HTM_THR_10;
      endcase
      case (cfg_level_r[`HTM_HYST_MSB:`HTM_HYST_LSB])
         3'h1: hyst_cfg = `HTM_HYST_2;
         3'h2: hyst_cfg = `HTM_HYST_3;
         3'h3: hyst_cfg = `HTM_HYST_5;
         3'h4: hyst_cfg = `HTM_HYST_7;
         3'h5: hyst_cfg = `HTM_HYST_10;
         default: hyst_cfg = `HTM_HYST_0;
      endcase
   end

   // Percent object scaled; product of at most 25500 fits in 16 bits
   assign pct_thr = 16'(ext8_r * PCT_STEP);

   always_comb begin
      thr_act = thr_cfg;
      if (ext_valid_r) begin
         case (src)
            htm_pkg::HTM_SRC_EXT16: thr_act = ext16_r;
            htm_pkg::HTM_SRC_EXT8: thr_act = pct_thr;
            htm_pkg::HTM_SRC_TEACH: thr_act = teach_r;
            default: thr_act = thr_cfg;
         endcase
      end
   end

   assign cif.meas = meas_r;
   assign cif.thr = thr_act;
   assign cif.hyst = hyst_cfg;
   assign cif.mode = cfg_level_r[`HTM_MODE_MSB:`HTM_MODE_LSB];

   // Free-running second tick for the cyclic schedule
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         pre_r <= '0;
      end else if (pre_r == PRE_LAST) begin
         pre_r <= '0;
      end else begin
         pre_r <= PW'(pre_r + 1'b1);
      end
   end
   assign tick = (pre_r == PRE_LAST);

   assign cyc_period = 11'(cfg_send_r[`HTM_CYC_MSB:`HTM_CYC_LSB]) *
                       `HTM_CYC_STEP_S;
   assign cyc_cnt_inc = 11'(cyc_cnt_r + 11'h001);
   assign cyc_fire = tick && (cyc_period != 11'h000) &&
                     (cyc_cnt_inc >= cyc_period);

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         cyc_cnt_r <= 11'h000;
      end else if (cyc_period == 11'h000 || cyc_fire) begin
         cyc_cnt_r <= 11'h000;
      end else if (tick) begin
         cyc_cnt_r <= cyc_cnt_inc;
      end
   end

   assign silent = (cif.act == htm_pkg::HTM_ACT_NONE);
   assign desired = silent ? limit_r : (cif.act == htm_pkg::HTM_ACT_ON);

   assign dly_on = dly_sec(cfg_delay_r[`HTM_DON_MSB:`HTM_DON_LSB]);
   assign dly_off = dly_sec(cfg_delay_r[`HTM_DOFF_MSB:`HTM_DOFF_LSB]);
   // Own prescaler so a delay starts on a whole-second boundary
   assign dly_tick = (dly_pre_r == PRE_LAST);
   assign dly_cnt_inc = 12'(dly_cnt_r + 12'h001);

   always_comb begin
      case (state_r)
         htm_pkg::HTM_ST_IDLE:
            apply = (desired != limit_r) &&
                    ((desired ? dly_on : dly_off) == 12'h000);
         htm_pkg::HTM_ST_WAIT_ON:
            apply = desired && dly_tick && (dly_cnt_inc >= dly_on);
         htm_pkg::HTM_ST_WAIT_OFF:
            apply = !desired && dly_tick && (dly_cnt_inc >= dly_off);
         default:
            apply = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         state_r <= htm_pkg::HTM_ST_IDLE;
         dly_cnt_r <= 12'h000;
         dly_pre_r <= '0;
      end else begin
         case (state_r)
            htm_pkg::HTM_ST_IDLE: begin
               dly_cnt_r <= 12'h000;
               dly_pre_r <= '0;
               if (desired != limit_r && !apply) begin
                  state_r <= desired ? htm_pkg::HTM_ST_WAIT_ON
                                     : htm_pkg::HTM_ST_WAIT_OFF;
               end
            end
            htm_pkg::HTM_ST_WAIT_ON,
            htm_pkg::HTM_ST_WAIT_OFF: begin
               if (apply || desired == limit_r) begin
                  state_r <= htm_pkg::HTM_ST_IDLE;
               end
               dly_pre_r <= dly_tick ? '0 : PW'(dly_pre_r + 1'b1);
               if (dly_tick) begin
                  dly_cnt_r <= dly_cnt_inc;
               end
            end
            default: state_r <= htm_pkg::HTM_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         limit_r <= 1'b0;
      end else if (apply) begin
         limit_r <= desired;
      end
   end

   assign chg_send = apply && cfg_send_r[`HTM_CHG_BIT];

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         tx_strobe_r <= 1'b0;
         tx_value_r <= 1'b0;
      end else begin
         tx_strobe_r <= chg_send || (cyc_fire && !silent);
         if (chg_send || (cyc_fire && !silent)) begin
            tx_value_r <= apply ? desired : limit_r;
         end
      end
   end

   assign o_avs_readdata = rdata_r;
   assign o_avs_waitrequest = wait_r;
   assign o_limit = limit_r;
   assign o_tx_strobe = tx_strobe_r;
   assign o_tx_value = tx_value_r;
endmodule

// >>> hdl/htm_params.svh
// Register map, field positions, reset values and timing constants
`ifndef HTM_PARAMS_SVH
`define HTM_PARAMS_SVH

`define HTM_ADDR_LEVEL 6'h00
`define HTM_ADDR_SEND 6'h04
`define HTM_ADDR_DELAY 6'h08
`define HTM_ADDR_MEAS 6'h0C
`define HTM_ADDR_EXT16 6'h10
`define HTM_ADDR_EXT8 6'h14
`define HTM_ADDR_TEACH 6'h18
`define HTM_ADDR_RELOAD 6'h1C
`define HTM_ADDR_STATUS 6'h20

`define HTM_THR_MSB 3
`define HTM_THR_LSB 0
`define HTM_HYST_MSB 6
`define HTM_HYST_LSB 4
`define HTM_MODE_MSB 11
`define HTM_MODE_LSB 8
`define HTM_SRC_MSB 13
`define HTM_SRC_LSB 12
`define HTM_CYC_MSB 6
`define HTM_CYC_LSB 0
`define HTM_CHG_BIT 8
`define HTM_DON_MSB 3
`define HTM_DON_LSB 0
`define HTM_DOFF_MSB 7
`define HTM_DOFF_LSB 4
`define HTM_TEACH_BIT 0

`define HTM_MASK_LEVEL 16'h3F7F
`define HTM_MASK_SEND 16'h017F
`define HTM_MASK_DELAY 16'h00FF
`define HTM_RST_LEVEL 16'h0000
`define HTM_RST_SEND 16'h0000
`define HTM_RST_DELAY 16'h0000

`define HTM_CLK_NS 10
`define HTM_SEC_NS 1000000000
`define HTM_CYC_STEP_S 11'h00A
`define HTM_PCT_STEP 16'h0064

`define HTM_THR_10 16'h03E8
`define HTM_THR_15 16'h05DC
`define HTM_THR_20 16'h07D0
`define HTM_THR_25 16'h09C4
`define HTM_THR_30 16'h0BB8
`define HTM_THR_35 16'h0DAC
`define HTM_THR_40 16'h0FA0
`define HTM_THR_50 16'h1388
`define HTM_THR_60 16'h1770
`define HTM_THR_70 16'h1B58
`define HTM_THR_80 16'h1F40
`define HTM_HYST_0 16'h0000
`define HTM_HYST_2 16'h00C8
`define HTM_HYST_3 16'h012C
`define HTM_HYST_5 16'h01F4
`define HTM_HYST_7 16'h02BC
`define HTM_HYST_10 16'h03E8

`define HTM_DLY_0 12'h000
`define HTM_DLY_1S 12'h001
`define HTM_DLY_3S 12'h003
`define HTM_DLY_5S 12'h005
`define HTM_DLY_10S 12'h00A
`define HTM_DLY_15S 12'h00F
`define HTM_DLY_30S 12'h01E
`define HTM_DLY_1M 12'h03C
`define HTM_DLY_3M 12'h0B4
`define HTM_DLY_5M 12'h12C
`define HTM_DLY_10M 12'h258
`define HTM_DLY_15M 12'h384
`define HTM_DLY_30M 12'h708
`define HTM_DLY_60M 12'hE10

`endif

// >>> hdl/htm_pkg.sv
// Types shared by the limit monitor modules
package htm_pkg;
   typedef enum logic [1:0] {
      HTM_ACT_OFF = 2'h0,
      HTM_ACT_ON = 2'h1,
      HTM_ACT_NONE = 2'h2
   } htm_act_t;
   typedef enum logic [1:0] {
      HTM_SRC_CFG = 2'h0,
      HTM_SRC_EXT16 = 2'h1,
      HTM_SRC_EXT8 = 2'h2,
      HTM_SRC_TEACH = 2'h3
   } htm_src_t;
   typedef enum logic [2:0] {
      HTM_ST_IDLE = 3'h1,
      HTM_ST_WAIT_ON = 3'h2,
      HTM_ST_WAIT_OFF = 3'h4
   } htm_state_t;
endpackage

// >>> verif/htm_chk_monitor.sv
// Port-level assertions for the humidity limit monitor
module htm_chk (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic o_limit,
   input wire logic o_tx_strobe,
   input wire logic o_tx_value
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   logic req;
   logic dead;
   assign req = i_avs_read || i_avs_write;
   // Unaligned, past status, or the write-only reload place
   assign dead = i_avs_address[1:0] != 2'h0 || i_avs_address > 6'h20 ||
      i_avs_address == 6'h1C;
   wait_one_a: assert property (
      req && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("Bus answer not after one wait");
   wait_short_a: assert property (
      !o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("Bus answer longer than one cycle");
   idle_quiet_a: assert property (
      !req && o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("Bus answer without request");
   rdata_hold_a: assert property (
      !$stable(o_avs_readdata) |-> !o_avs_waitrequest)
      else $error("Read data moved outside an answer");
   dead_read_a: assert property (
      i_avs_read && o_avs_waitrequest && dead |=> o_avs_readdata == 32'h0)
      else $error("Unmapped read not zero");
   wr_rdata_a: assert property (
      i_avs_write |=> $stable(o_avs_readdata))
      else $error("Write disturbed read data");
   tx_value_a: assert property (
      o_tx_strobe |-> o_tx_value == o_limit)
      else $error("Telegram value differs from limit");
   tx_hold_a: assert property (
      !$stable(o_tx_value) |-> o_tx_strobe)
      else $error("Telegram value moved without a send");
endmodule

// >>> verif/htm_fbus_model.sv
// Field bus sink that counts limit telegrams and keeps the last value
module htm_fbus_model (
   input wire logic i_clk_sys,
   input wire logic i_tx_strobe,
   input wire logic i_tx_value,
   output int o_count,
   output logic o_last
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_count = 0;
   initial o_last = 1'b0;
   always @(posedge i_clk_sys) begin
      if (i_tx_strobe === 1'b1) begin
         o_count <= o_count + 1;
         o_last <= i_tx_value;
      end
   end
endmodule

// >>> verif/htm_monitor_tb.sv
// Self-checking bench for the humidity limit monitor
`include "htm_params.svh"

module htm_monitor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CPS = 10;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] adr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic wreq;
   logic lim;
   logic stb;
   logic val;
   logic last;
   logic [31:0] got;
   int cnt;
   int c0;
   int fails = 0;
   int check_count = 0;

   always #5 clk = ~clk;

   htm_monitor #(.CYCLES_PER_SEC(CPS)) i_htm_monitor (
      .i_clk_sys(clk), .i_reset_n(rst_n), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
      .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .o_limit(lim), .o_tx_strobe(stb),
      .o_tx_value(val));

   htm_fbus_model i_htm_fbus_model (.i_clk_sys(clk), .i_tx_strobe(stb),
      .i_tx_value(val), .o_count(cnt), .o_last(last));

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [5:0] a,
         input logic [31:0] d);
      adr <= a;
      wdat <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      got = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(got, exp);
   endtask

   task automatic meas(input logic [15:0] v);
      bus(1'b1, `HTM_ADDR_MEAS, {16'h0000, v});
      tick(4);
   endtask

   task automatic thr_is(input logic [15:0] exp);
      bus(1'b0, `HTM_ADDR_STATUS, 32'h0);
      chk({16'h0000, got[31:16]}, {16'h0000, exp});
   endtask

   task automatic t_regs;
      rdchk(`HTM_ADDR_LEVEL, 32'h0);
      rdchk(`HTM_ADDR_SEND, 32'h0);
      rdchk(`HTM_ADDR_DELAY, 32'h0);
      bus(1'b1, `HTM_ADDR_LEVEL, 32'hFFFFFFFF);
      rdchk(`HTM_ADDR_LEVEL, 32'h00003F7F);
      rdchk(6'h24, 32'h0);
      rdchk(6'h02, 32'h0);
      rdchk(`HTM_ADDR_RELOAD, 32'h0);
      bus(1'b1, `HTM_ADDR_LEVEL, 32'h0);
   endtask

   task automatic t_levels;
      logic [15:0] tab [11] = '{16'h03E8, 16'h05DC, 16'h07D0, 16'h09C4,
         16'h0BB8, 16'h0DAC, 16'h0FA0, 16'h1388, 16'h1770, 16'h1B58,
         16'h1F40};
      for (int i = 0; i < 11; i++) begin
         bus(1'b1, `HTM_ADDR_LEVEL, 32'(i));
         thr_is(tab[i]);
      end
   endtask

   task automatic t_change;
      bus(1'b1, `HTM_ADDR_LEVEL, 32'h10);
      bus(1'b1, `HTM_ADDR_SEND, 32'h100);
      c0 = cnt;
      meas(16'd1001);
      chk(32'(lim), 32'h1);
      chk(cnt, c0 + 1);
      chk(32'(last), 32'h1);
      meas(16'd850);
      chk(32'(lim), 32'h1);
      meas(16'd799);
      chk(32'(lim), 32'h0);
      chk(cnt, c0 + 2);
      chk(32'(last), 32'h0);
      bus(1'b1, `HTM_ADDR_SEND, 32'h0);
      meas(16'd1001);
      chk(32'(lim), 32'h1);
      chk(cnt, c0 + 2);
      meas(16'd700);
   endtask

   task automatic t_modes;
      logic [3:0] hi = 4'b1001;
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, `HTM_ADDR_LEVEL, 32'h10 | (m << 8));
         meas(16'd1300);
         chk(32'(lim), 32'(hi[m]));
         meas(16'd500);
         chk(32'(lim), 32'(!hi[m]));
      end
   endtask

   task automatic t_delay;
      bus(1'b1, `HTM_ADDR_LEVEL, 32'h10);
      bus(1'b1, `HTM_ADDR_SEND, 32'h100);
      bus(1'b1, `HTM_ADDR_DELAY, 32'h21);
      c0 = cnt;
      meas(16'd1001);
      chk(32'(lim), 32'h0);
      tick(14);
      chk(32'(lim), 32'h1);
      chk(cnt, c0 + 1);
      meas(16'd700);
      tick(10);
      meas(16'd1001);
      tick(40);
      chk(32'(lim), 32'h1);
      chk(cnt, c0 + 1);
      meas(16'd700);
      tick(35);
      chk(32'(lim), 32'h0);
      chk(32'(last), 32'h0);
      bus(1'b1, `HTM_ADDR_DELAY, 32'h0);
   endtask

   task automatic t_cyclic;
      bus(1'b1, `HTM_ADDR_SEND, 32'h1);
      c0 = cnt;
      tick(250);
      chk(cnt, c0 + 2);
      chk(32'(last), 32'h0);
      bus(1'b1, `HTM_ADDR_LEVEL, 32'h810);
      meas(16'd1300);
      c0 = cnt;
      tick(250);
      chk(cnt, c0);
      chk(32'(lim), 32'h0);
      bus(1'b1, `HTM_ADDR_SEND, 32'h0);
      // Leave the silent mode so a stray cyclic send would show
      bus(1'b1, `HTM_ADDR_LEVEL, 32'h10);
      c0 = cnt;
      tick(250);
      chk(32'(lim), 32'h1);
      chk(cnt, c0);
   endtask

   task automatic t_ext;
      bus(1'b1, `HTM_ADDR_LEVEL, 32'h1010);
      bus(1'b1, `HTM_ADDR_SEND, 32'h100);
      meas(16'd1300);
      chk(32'(lim), 32'h1);
      bus(1'b1, `HTM_ADDR_EXT16, 32'h07D0);
      tick(4);
      chk(32'(lim), 32'h0);
      thr_is(16'h07D0);
      bus(1'b1, `HTM_ADDR_RELOAD, 32'h0);
      tick(4);
      chk(32'(lim), 32'h1);
      thr_is(16'h03E8);
      bus(1'b1, `HTM_ADDR_LEVEL, 32'h2010);
      bus(1'b1, `HTM_ADDR_EXT8, 32'h14);
      tick(4);
      thr_is(16'h07D0);
      bus(1'b1, `HTM_ADDR_RELOAD, 32'h0);
      bus(1'b1, `HTM_ADDR_LEVEL, 32'h3010);
      bus(1'b1, `HTM_ADDR_TEACH, 32'h1);
      thr_is(16'h0514);
      meas(16'd1050);
      chk(32'(lim), 32'h0);
   endtask

   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_regs;
      t_levels;
      t_change;
      t_modes;
      t_delay;
      t_cyclic;
      t_ext;
      report_and_stop;
   end

   // Run needs about 1200 cycles
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      report_and_stop;
   end
endmodule

bind htm_monitor htm_chk i_htm_chk (.i_clk_sys, .i_reset_n,
   .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
   .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_limit,
   .o_tx_strobe, .o_tx_value);
